// ==== rtl/perom_setup.sv ====
// expansion rom image setup: config registers, rom hit decode, translation
// assumes host requests arrive synchronous to mclk from the pci target logic
//
// Operation
// - rom base address held in bits 31..16 of rom base register
// - image answers only while its enable bit is set
// - two-bit rom width field, read only, loaded from eeprom
// - three-bit block size field, read only, loaded from eeprom
// - transfer code lines driven from read-only four-bit eeprom field
// - translation address in bits 31..16 of rom control, eeprom loaded
// - rom base address can be loaded from eeprom at start-up
// - host access blocked while host-off bit set, accepted once cleared
// - messaging-unit on relocates memory base register to offset 018h
// - eeprom programmed through control register, product data writes
`timescale 1ns/1ps
module perom_setup
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire perom_pkg::perom_req_t hostReq,
  input  wire perom_pkg::perom_req_t localReq,
  input  wire logic                 eepLoad,
  input  wire perom_pkg::perom_load_t eepData,
  input  wire logic [15:0]          eepBase,
  input  wire logic                 memValid,
  input  wire logic [31:0]          memAddr,
  output logic [31:0]               rdData,
  output logic                      rdAck,
  output logic                      hostRetry,
  output logic                      romHit,
  output logic [31:0]               romAddr,
  output logic [3:0]                transferCodeLines,
  output logic                      eepWrite,
  output logic [31:0]               eepWriteData
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic        memorySpaceEnable_reg;
  logic [15:0] romBase_reg;
  logic        imageEnable_reg;
  perom_pkg::perom_load_t romCtl_reg;
  logic        hostAccessOff_reg;
  logic        messagingUnitOn_reg;
  logic [31:0] memBase_reg;
  logic        hostOk;
  logic        hostWr;
  logic        hostRd;
  logic [7:0]  memBaseIdx;
  logic [7:0]  rdIdx;

  // host blocked while host-off set; local side always allowed
  assign hostOk = ~hostAccessOff_reg;
  assign hostWr = hostReq.wr & hostOk;
  assign hostRd = hostReq.rd & hostOk;
  // memory base register moves when messaging unit is on
  assign memBaseIdx = messagingUnitOn_reg ? perom_pkg::MEM_BASE_RELOC
                                          : perom_pkg::MEM_BASE_IDX;
  // host read wins the shared read index over a local read
  assign rdIdx = hostRd ? hostReq.idx : localReq.idx;

  // command register memory-space gate, written by host or local side
  always_ff @(posedge mclk)
  begin
    if (rst)
      memorySpaceEnable_reg <= 1'b0;
    else if (hostWr && hostReq.idx == perom_pkg::CMD_STATUS_IDX)
      memorySpaceEnable_reg <= hostReq.data[perom_pkg::MEM_SPACE_BIT];
    else if (localReq.wr && localReq.idx == perom_pkg::CMD_STATUS_IDX)
      memorySpaceEnable_reg <= localReq.data[perom_pkg::MEM_SPACE_BIT];
  end

  // rom base: eeprom load wins so start-up config is never lost
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      romBase_reg     <= 16'h0000;
      imageEnable_reg <= 1'b0;
    end
    else if (eepLoad)
      romBase_reg <= eepBase;
    else if (hostWr && hostReq.idx == perom_pkg::ROM_BASE_IDX)
    begin
      romBase_reg     <= hostReq.data[31:perom_pkg::UPPER_LO];
      imageEnable_reg <= hostReq.data[perom_pkg::IMAGE_EN_BIT];
    end
  end

  // read-only rom control fields, only the eeprom load changes them
  always_ff @(posedge mclk)
  begin
    if (rst)
      romCtl_reg <= '0;
    else if (eepLoad)
      romCtl_reg <= eepData;
  end

  // local-only control bits: host-off and messaging unit enable
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      hostAccessOff_reg   <= perom_pkg::HOST_OFF_RESET;
      messagingUnitOn_reg <= 1'b0;
    end
    else if (localReq.wr)
    begin
      if (localReq.idx == perom_pkg::MISC_CTRL2_IDX)
        hostAccessOff_reg <= localReq.data[perom_pkg::HOST_OFF_BIT];
      else if (localReq.idx == perom_pkg::MSG_CTRL_IDX)
        messagingUnitOn_reg <= localReq.data[perom_pkg::MSG_ON_BIT];
    end
  end

  // memory base register at whichever offset is current
  always_ff @(posedge mclk)
  begin
    if (rst)
      memBase_reg <= perom_pkg::ZERO_WORD;
    else if (hostWr && hostReq.idx == memBaseIdx)
      memBase_reg <= hostReq.data;
  end

  // eeprom write pulse from control or product-data register writes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      eepWrite     <= 1'b0;
      eepWriteData <= perom_pkg::ZERO_WORD;
    end
    else
    begin
      eepWrite <= (localReq.wr && localReq.idx == perom_pkg::EEPROM_CTRL_IDX)
                | (hostWr && hostReq.idx == perom_pkg::PROD_DATA_IDX);
      if (hostWr && hostReq.idx == perom_pkg::PROD_DATA_IDX)
        eepWriteData <= hostReq.data;
      else if (localReq.wr)
        eepWriteData <= localReq.data;
    end
  end

  // read mux: host read has priority; unmapped reads return zero
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdData    <= perom_pkg::ZERO_WORD;
      rdAck     <= 1'b0;
      hostRetry <= 1'b0;
    end
    else
    begin
      rdAck     <= hostRd | localReq.rd;
      hostRetry <= (hostReq.rd | hostReq.wr) & ~hostOk;
      if (rdIdx == perom_pkg::CMD_STATUS_IDX)
        rdData <= {30'h0, memorySpaceEnable_reg, 1'b0};
      else if (rdIdx == perom_pkg::ROM_BASE_IDX)
        rdData <= {romBase_reg, 15'h0000, imageEnable_reg};
      else if (rdIdx == perom_pkg::ROM_CTRL_IDX)
        rdData <= {romCtl_reg.translationField, 4'h0,
                   romCtl_reg.transferCode, 1'b0, romCtl_reg.romBlockSize,
                   2'h0, romCtl_reg.romWidthField};
      else if (rdIdx == perom_pkg::MSG_CTRL_IDX)
        rdData <= {31'h0, messagingUnitOn_reg};
      else if (rdIdx == perom_pkg::MISC_CTRL2_IDX)
        rdData <= {31'h0, hostAccessOff_reg};
      else if (rdIdx == memBaseIdx)
        rdData <= memBase_reg;
      else
        rdData <= perom_pkg::ZERO_WORD;
    end
  end

  // ----------------------------------------------------------------
  // rom hit decode and address translation
  // ----------------------------------------------------------------
  // hit needs image on, memory space on and upper bits matching base
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      romHit            <= 1'b0;
      romAddr           <= perom_pkg::ZERO_WORD;
      transferCodeLines <= 4'h0;
    end
    else
    begin
      romHit <= memValid & imageEnable_reg
              & memorySpaceEnable_reg & hostOk
              & (memAddr[31:perom_pkg::UPPER_LO] == romBase_reg);
      romAddr <= {romCtl_reg.translationField,
                  memAddr[perom_pkg::UPPER_LO-1:0]};
      transferCodeLines <= romCtl_reg.transferCode;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence hitCause;
    memValid && imageEnable_reg && memorySpaceEnable_reg && hostOk
      && memAddr[31:perom_pkg::UPPER_LO] == romBase_reg;
  endsequence
  AST_HIT: assert property (@(posedge mclk) disable iff (rst)
    hitCause |=> romHit) else $error("rom hit missed");
  AST_NOHIT_DIS: assert property (@(posedge mclk) disable iff (rst)
    !imageEnable_reg |=> !romHit) else $error("hit while disabled");
  AST_TC: assert property (@(posedge mclk) disable iff (rst)
    ##1 transferCodeLines == $past(romCtl_reg.transferCode))
    else $error("transfer code wrong");
  AST_XLATE: assert property (@(posedge mclk) disable iff (rst)
    ##1 romAddr[31:16] == $past(romCtl_reg.translationField))
    else $error("translation wrong");
  AST_RO: assert property (@(posedge mclk) disable iff (rst)
    !eepLoad |=> $stable(romCtl_reg))
    else $error("ro field changed");
  AST_BLOCK: assert property (@(posedge mclk) disable iff (rst)
    hostAccessOff_reg && hostReq.wr |=> $stable(romBase_reg) || $past(eepLoad))
    else $error("host write while off");
  // a refused host request must come back as a retry one cycle later
  AST_RETRY: assert property (@(posedge mclk) disable iff (rst)
    hostAccessOff_reg && (hostReq.rd || hostReq.wr) |=> hostRetry)
    else $error("host not retried");
  AST_BASE: assert property (@(posedge mclk) disable iff (rst)
    eepLoad |=> romBase_reg == $past(eepBase))
    else $error("base load");
  // reads at the moved offset must return the memory base register
  AST_RELOC: assert property (@(posedge mclk) disable iff (rst)
    messagingUnitOn_reg && hostRd && hostReq.idx == perom_pkg::MEM_BASE_RELOC
    |=> rdData == $past(memBase_reg))
    else $error("reloc");
  AST_EEPW: assert property (@(posedge mclk) disable iff (rst)
    hostWr && hostReq.idx == perom_pkg::PROD_DATA_IDX |=> eepWrite)
    else $error("product data write missed");
endmodule // perom_setup

// ==== rtl/perom_pkg.sv ====
// package for the expansion rom image setup block: offsets, fields, types
// assumes a register-access port with word indices and 32-bit data
package perom_pkg;
  // ----------------------------------------------------------------
  // register indices on the configuration/register port
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_STATUS_IDX  = 8'h01;
  localparam logic [7:0] ROM_BASE_IDX    = 8'h0c;
  localparam logic [7:0] ROM_CTRL_IDX    = 8'h20;
  localparam logic [7:0] MSG_CTRL_IDX    = 8'h21;
  localparam logic [7:0] MISC_CTRL2_IDX  = 8'h22;
  localparam logic [7:0] EEPROM_CTRL_IDX = 8'h23;
  localparam logic [7:0] PROD_DATA_IDX   = 8'h24;
  localparam logic [7:0] MEM_BASE_IDX    = 8'h04;
  // relocated memory base offset (byte 018h as word index)
  localparam logic [7:0] MEM_BASE_RELOC  = 8'h06;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MEM_SPACE_BIT = 1;
  localparam int IMAGE_EN_BIT  = 0;
  localparam int HOST_OFF_BIT  = 0;
  localparam int MSG_ON_BIT    = 0;
  localparam int WIDTH_LO      = 0;
  localparam int BLOCK_LO      = 4;
  localparam int TCODE_LO      = 8;
  localparam int UPPER_LO      = 16;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic        HOST_OFF_RESET = 1'b1;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] translationField;
    logic [3:0]  transferCode;
    logic [2:0]  romBlockSize;
    logic [1:0]  romWidthField;
  } perom_load_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic [31:0] data;
  } perom_req_t;
endpackage

// ==== verification/perom_host_model.sv ====
// pci host model: config requests and memory reads toward the rom block
// assumes mclk from the bench; the bench sequence calls its tasks
`timescale 1ns/1ps
module perom_host_model
(
  input  wire logic             mclk,
  output perom_pkg::perom_req_t hostReq,
  output logic                  memValid,
  output logic [31:0]           memAddr
);
  initial
  begin
    hostReq = '0;
    memValid = 1'b0;
    memAddr = 32'h0;
  end
  // one-cycle request; released lines show inverted data, not the last
  task automatic cfg(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d);
    @(negedge mclk);
    hostReq = '{wr, ~wr, idx, d};
    @(negedge mclk);
    hostReq = '{1'b0, 1'b0, idx, ~d};
  endtask
  // memory read; the bench sets memory space first when it wants hits
  task automatic mem(input logic [31:0] a);
    @(negedge mclk);
    memValid = 1'b1;
    memAddr = a;
    @(negedge mclk);
    memValid = 1'b0;
    memAddr = ~a;
  endtask
endmodule // perom_host_model

// ==== verification/perom_setup_tb.sv ====
// self-checking bench for the expansion rom image setup block
// assumes the host model is compiled first
`timescale 1ns/1ps
module perom_setup_tb;
  logic                   mclk;
  logic                   rst;
  perom_pkg::perom_req_t  hostReq;
  perom_pkg::perom_req_t  localReq;
  logic                   eepLoad;
  perom_pkg::perom_load_t eepData;
  logic [15:0]            eepBase;
  logic                   memValid;
  logic [31:0]            memAddr;
  logic [31:0]            rdData;
  logic                   rdAck;
  logic                   hostRetry;
  logic                   romHit;
  logic [31:0]            romAddr;
  logic [3:0]             tcOut;
  logic                   eepWrite;
  logic [31:0]            eepWd;
  logic [35:0]            qRd[$];
  logic [35:0]            qRom[$];
  logic [35:0]            qEep[$];
  int                     fail_count = 0;
  int                     comparisons = 0;
  int                     expRetry = 0;
  int                     seenRetry = 0;
  logic                   hostOff = 1'b1;
  perom_setup dut_u (.mclk(mclk), .rst(rst), .hostReq(hostReq),
    .localReq(localReq), .eepLoad(eepLoad), .eepData(eepData),
    .eepBase(eepBase), .memValid(memValid), .memAddr(memAddr),
    .rdData(rdData), .rdAck(rdAck), .hostRetry(hostRetry),
    .romHit(romHit), .romAddr(romAddr), .transferCodeLines(tcOut),
    .eepWrite(eepWrite), .eepWriteData(eepWd));
  perom_host_model host_u (.mclk(mclk), .hostReq(hostReq),
    .memValid(memValid), .memAddr(memAddr));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // host access; while host-off only a retry is expected
  task automatic hAcc(input logic wr, input logic [7:0] idx,
                      input logic [31:0] d, input logic [31:0] e);
    if (hostOff)
      expRetry++;
    else if (!wr)
      qRd.push_back({4'h0, e});
    host_u.cfg(wr, idx, d);
  endtask
  task automatic lAcc(input logic wr, input logic [7:0] idx,
                      input logic [31:0] d, input logic [31:0] e);
    if (!wr)
      qRd.push_back({4'h0, e});
    @(negedge mclk);
    localReq = '{wr, ~wr, idx, d};
    if (wr && idx == perom_pkg::MISC_CTRL2_IDX)
      hostOff = d[perom_pkg::HOST_OFF_BIT];
    @(negedge mclk);
    localReq = '{1'b0, 1'b0, idx, ~d};
  endtask
  // results compared against the oldest note; empty queue pops unknown
  always @(negedge mclk)
  begin
    if (rdAck === 1'b1)
      chk({4'h0, rdData}, qRd.pop_front());
    if (romHit === 1'b1)
      chk({tcOut, romAddr}, qRom.pop_front());
    if (eepWrite === 1'b1)
      chk({4'h0, eepWd}, qEep.pop_front());
    if (hostRetry === 1'b1)
      seenRetry++;
  end
  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic [31:0] ctl;
    logic [15:0] base;
    rst = 1'b1;
    localReq = '0;
    eepLoad = 1'b0;
    eepData = '0;
    eepBase = 16'h0;
    r = $urandom(85);
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    hAcc(1'b0, perom_pkg::CMD_STATUS_IDX, 32'h0, 32'h0);
    lAcc(1'b1, perom_pkg::MISC_CTRL2_IDX, 32'h0, 32'h0);
    r = $urandom;
    eepData = r[24:0];
    r = $urandom;
    eepBase = r[15:0];
    eepLoad = 1'b1;
    @(negedge mclk);
    eepLoad = 1'b0;
    ctl = {eepData.translationField, 4'h0, eepData.transferCode, 1'b0,
           eepData.romBlockSize, 2'h0, eepData.romWidthField};
    lAcc(1'b0, perom_pkg::ROM_CTRL_IDX, 32'h0, ctl);
    lAcc(1'b0, perom_pkg::ROM_BASE_IDX, 32'h0, {eepBase, 16'h0});
    hAcc(1'b1, perom_pkg::ROM_CTRL_IDX, ~ctl, 32'h0);
    hAcc(1'b0, perom_pkg::ROM_CTRL_IDX, 32'h0, ctl);
    base = ~eepBase;
    hAcc(1'b1, perom_pkg::ROM_BASE_IDX, {base, 16'h0001}, 32'h0);
    hAcc(1'b0, perom_pkg::ROM_BASE_IDX, 32'h0, {base, 16'h0001});
    host_u.mem({base, r[31:16]}); // no hit: memory space off
    hAcc(1'b1, perom_pkg::CMD_STATUS_IDX, 32'h2, 32'h0);
    qRom.push_back({eepData.transferCode, eepData.translationField,
                    r[31:16]});
    host_u.mem({base, r[31:16]});
    host_u.mem({~base, r[31:16]}); // upper bits differ
    hAcc(1'b1, perom_pkg::ROM_BASE_IDX, {base, 16'h0}, 32'h0);
    host_u.mem({base, r[31:16]}); // image off
    lAcc(1'b1, perom_pkg::MSG_CTRL_IDX, 32'h1, 32'h0);
    hAcc(1'b1, perom_pkg::MEM_BASE_RELOC, {r[15:0], 16'h0}, 32'h0);
    hAcc(1'b0, perom_pkg::MEM_BASE_RELOC, 32'h0,
         {r[15:0], 16'h0});
    lAcc(1'b1, perom_pkg::MSG_CTRL_IDX, 32'h0, 32'h0);
    hAcc(1'b0, perom_pkg::MEM_BASE_IDX, 32'h0, {r[15:0], 16'h0});
    qEep.push_back({4'h0, ctl});
    hAcc(1'b1, perom_pkg::PROD_DATA_IDX, ctl, 32'h0);
    lAcc(1'b0, 8'h7f, 32'h0, 32'h0);
    lAcc(1'b1, perom_pkg::MISC_CTRL2_IDX, 32'h1, 32'h0);
    hAcc(1'b1, perom_pkg::ROM_BASE_IDX, 32'h0, 32'h0);
    lAcc(1'b0, perom_pkg::ROM_BASE_IDX, 32'h0, {base, 16'h0});
    repeat (5) @(negedge mclk);
    chk(36'(seenRetry), 36'(expRetry));
    chk(36'(qRd.size() + qRom.size() + qEep.size()), 36'h0);
    end_sim();
  end
  // hang guard
  initial
  begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    end_sim();
  end
endmodule // perom_setup_tb
